// ### ptw_pkg.sv
// Package of constants and carrier types for the trap and edge-wake logic
package ptw_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] WAKE_EN_OFS = 8'h04;
    localparam logic [7:0] WAKE_EDGE_OFS = 8'h08;
    localparam logic [7:0] WAKE_PEND_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] VECTOR_OFS = 8'h14;

    // Field positions
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_GROUP_BIT = 1;
    localparam int STAT_PORT_REQ_BIT = 0;
    localparam int STAT_BOOT_BIT = 1;
    localparam int STAT_LOST_BIT = 2;
    localparam int STAT_IRQ_BIT = 3;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] WAKE_EN_RST = 8'h00;
    localparam logic [7:0] WAKE_EDGE_RST = 8'h00;
    localparam logic [7:0] WAKE_PEND_RST = 8'h00;

    // Core-side encodings
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [7:0] STACK_LIMIT = 8'h6f;
    localparam logic [14:0] OVERPOP_PC = 15'h7fff;
    localparam logic [14:0] FLASH_TOP = 15'h1fff;

    // Vector low bytes
    localparam logic [7:0] VEC_TRAP = 8'hfe;
    localparam logic [7:0] VEC_TOP_PERIPH = 8'hfa;
    localparam logic [7:0] VEC_PORT = 8'he2;
    localparam logic [7:0] VEC_DEFAULT = 8'he0;
    localparam int NUM_PERIPH = 12;
    localparam int NUM_LINES = 8;

    // Which routine the core is running
    typedef enum logic [1:0] {
        SVC_NONE = 2'b00,
        SVC_MASK = 2'b01,
        SVC_TRAP = 2'b10
    } ptw_svc_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ptw_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ptw_apb_rsp_t;

endpackage : ptw_pkg

// ### ptw_irq_ctrl.sv
// Software-trap flag, vector arbitration and eight-line edge wake unit
`timescale 1ns/10ps
module ptw_irq_ctrl
    import ptw_pkg::*;
(
    // Clock and reset
    input wire logic sysClk,
    input wire logic resetn,
    // APB register port
    input wire ptw_apb_req_t apbReq,
    output ptw_apb_rsp_t apbRsp,
    // Instruction fetch
    input wire logic fetchLoad,
    input wire logic [14:0] fetchAddr,
    input wire logic [7:0] flashData,
    output logic instrValid,
    output logic [7:0] instrOut,
    // Stack pop check
    input wire logic stackPop,
    input wire logic [7:0] stackPopAddr,
    output logic pcLoad,
    output logic [14:0] pcLoadValue,
    // Trap entry
    output logic trapTaken,
    output logic [14:0] trapReturnAddr,
    // Core instruction events
    input wire logic clearPendingInstr,
    input wire logic vectorSelectInstr,
    input wire logic returnFromIrqInstr,
    input wire logic irqAccepted,
    output logic [7:0] vectorLow,
    output logic irqToCore,
    // Other maskable sources, bit 0 ranks 3, enable-qualified
    input wire logic [NUM_PERIPH-1:0] periphReq,
    // Boot ROM and low-power state
    input wire logic bootActive,
    input wire logic haltIdle,
    output logic wakeup,
    output logic wakeToIsr,
    // Port pins
    input wire logic [NUM_LINES-1:0] portPins
);

    ////////////////////////////////////////////////////////////////////
    logic trapPending;
    logic [1:0] ctrl;
    logic [7:0] wakeEn;
    logic [7:0] wakeEdge;
    logic [7:0] wakePend;
    logic lostInBoot;
    ptw_svc_t svc;
    logic [7:0] pinSync1, pinSync2, pinPrev, edgeHit;
    logic [7:0] next_vector;
    logic [7:0] fetchWord;
    logic global_irq_enable, groupEn, portReq, trapEvent;
    logic apbWrite, apbRead, addrHit;
    logic [31:0] rdMux;

    assign global_irq_enable = ctrl[CTRL_GIE_BIT];
    assign groupEn = ctrl[CTRL_GROUP_BIT];

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped offsets
    assign apbWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign apbRead = apbReq.psel & apbReq.penable & ~apbReq.pwrite;

    // The trap flag is deliberately left out of every readable word
    always_comb begin
        addrHit = 1'b1;
        rdMux = 32'h0000_0000;
        case (apbReq.paddr)
            CTRL_OFS: rdMux[1:0] = ctrl;
            WAKE_EN_OFS: rdMux[7:0] = wakeEn;
            WAKE_EDGE_OFS: rdMux[7:0] = wakeEdge;
            WAKE_PEND_OFS: rdMux[7:0] = wakePend;
            STATUS_OFS: begin
                rdMux[STAT_PORT_REQ_BIT] = portReq;
                rdMux[STAT_BOOT_BIT] = bootActive;
                rdMux[STAT_LOST_BIT] = lostInBoot;
                rdMux[STAT_IRQ_BIT] = irqToCore;
            end
            VECTOR_OFS: rdMux[7:0] = vectorLow;
            default: addrHit = 1'b0;
        endcase
    end

    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~addrHit;
    assign apbRsp.prdata = apbRead ? rdMux : 32'h0000_0000;

    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= CTRL_RST;
            wakeEn <= WAKE_EN_RST;
            wakeEdge <= WAKE_EDGE_RST;
        end else if (apbWrite) begin
            case (apbReq.paddr)
                CTRL_OFS: ctrl <= apbReq.pwdata[1:0];
                WAKE_EN_OFS: wakeEn <= apbReq.pwdata[7:0];
                WAKE_EDGE_OFS: wakeEdge <= apbReq.pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fetch path: empty flash and the overpop location read as zero
    always_comb begin
        fetchWord = flashData;
        if (fetchAddr > FLASH_TOP || fetchAddr == OVERPOP_PC) begin
            fetchWord = TRAP_OPCODE;
        end
    end

    assign trapEvent = fetchLoad & (fetchWord == TRAP_OPCODE);

    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            instrValid <= 1'b0;
            instrOut <= 8'h00;
            trapTaken <= 1'b0;
            trapReturnAddr <= 15'h0000;
        end else begin
            instrValid <= fetchLoad;
            trapTaken <= trapEvent;
            if (fetchLoad) begin
                instrOut <= fetchWord;
            end
            if (trapEvent) begin
                trapReturnAddr <= fetchAddr;
            end
        end
    end

    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            pcLoad <= 1'b0;
            pcLoadValue <= 15'h0000;
        end else begin
            pcLoad <= stackPop & (stackPopAddr > STACK_LIMIT);
            pcLoadValue <= OVERPOP_PC;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trap pending flag: a new trap wins over a clear in the same cycle
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            trapPending <= 1'b0;
        end else if (trapEvent) begin
            trapPending <= 1'b1;
        end else if (clearPendingInstr) begin
            trapPending <= 1'b0;
        end
    end

    // Routine in progress; trap entry may cut into any routine
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            svc <= SVC_NONE;
        end else begin
            case (svc)
                SVC_NONE: begin
                    if (trapEvent) begin
                        svc <= SVC_TRAP;
                    end else if (irqAccepted) begin
                        svc <= SVC_MASK;
                    end
                end
                SVC_MASK: begin
                    if (trapEvent) begin
                        svc <= SVC_TRAP;
                    end else if (returnFromIrqInstr) begin
                        svc <= SVC_NONE;
                    end
                end
                SVC_TRAP: begin
                    if (returnFromIrqInstr && !trapPending) begin
                        svc <= SVC_NONE;
                    end
                end
                default: svc <= SVC_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port pins cross into the core clock through two flops
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            pinSync1 <= 8'h00;
            pinSync2 <= 8'h00;
            pinPrev <= 8'h00;
        end else begin
            pinSync1 <= portPins;
            pinSync2 <= pinSync1;
            pinPrev <= pinSync2;
        end
    end

    // Edge select bit high picks falling edges
    assign edgeHit = (wakeEdge & pinPrev & ~pinSync2) |
        (~wakeEdge & ~pinPrev & pinSync2);

    // Pending bits clear on write-one; a same-cycle edge keeps its bit
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            wakePend <= WAKE_PEND_RST;
        end else if (apbWrite && apbReq.paddr == WAKE_PEND_OFS) begin
            wakePend <= (wakePend & ~apbReq.pwdata[7:0]) | edgeHit;
        end else begin
            wakePend <= wakePend | edgeHit;
        end
    end

    // An edge on a line already held during boot is lost and sets lostInBoot
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            lostInBoot <= 1'b0;
        end else if (bootActive && |(edgeHit & wakePend)) begin
            lostInBoot <= 1'b1;
        end else if (apbWrite && apbReq.paddr == STATUS_OFS &&
                apbReq.pwdata[STAT_LOST_BIT]) begin
            lostInBoot <= 1'b0;
        end
    end

    assign portReq = global_irq_enable & groupEn & |(wakeEn & wakePend);

    ////////////////////////////////////////////////////////////////////
    // Maskable request to the core
    always_comb begin
        irqToCore = 1'b0;
        if (global_irq_enable && !bootActive && !trapPending && svc == SVC_NONE) begin
            irqToCore = portReq | (|periphReq);
        end
    end

    // Wake from halt or idle, with or without the routine first
    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            wakeup <= 1'b0;
            wakeToIsr <= 1'b0;
        end else begin
            wakeup <= haltIdle & |(edgeHit & wakeEn);
            wakeToIsr <= haltIdle & |(edgeHit & wakeEn) & global_irq_enable & groupEn &
                ~bootActive;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Vector arbitration, lowest rank written first, last write wins
    always_comb begin
        next_vector = VEC_DEFAULT;
        if (portReq) begin
            next_vector = VEC_PORT;
        end
        // Walk upwards in rank so that bit 0 is written last and wins
        for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
            if (periphReq[i]) begin
                next_vector = VEC_TOP_PERIPH - 8'(2 * i);
            end
        end
        if (trapPending || trapEvent) begin
            next_vector = VEC_TRAP;
        end
    end

    always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            vectorLow <= VEC_DEFAULT;
        end else if (vectorSelectInstr) begin
            vectorLow <= next_vector;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_trapLoad;
        fetchLoad && fetchWord == TRAP_OPCODE;
    endsequence

    property p_trap_set;
        @(posedge sysClk) disable iff (!resetn)
        s_trapLoad |=> trapPending && trapTaken;
    endproperty
    a_trap_set: assert property (p_trap_set)
        else $error("trap load did not set flag");

    property p_flag_clear;
        @(posedge sysClk) disable iff (!resetn)
        $fell(trapPending) |-> $past(clearPendingInstr) && !$past(trapEvent);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("trap flag cleared without instruction");

    property p_clear_works;
        @(posedge sysClk) disable iff (!resetn)
        clearPendingInstr && !trapEvent |=> !trapPending;
    endproperty
    a_clear_works: assert property (p_clear_works)
        else $error("clear instruction left flag set");

    property p_empty_fetch;
        @(posedge sysClk) disable iff (!resetn)
        fetchLoad && fetchAddr > FLASH_TOP |=>
            instrValid && instrOut == TRAP_OPCODE && trapTaken;
    endproperty
    a_empty_fetch: assert property (p_empty_fetch)
        else $error("empty flash fetch not a trap");

    property p_overpop;
        @(posedge sysClk) disable iff (!resetn)
        stackPop && stackPopAddr > STACK_LIMIT |=>
            pcLoad && pcLoadValue == OVERPOP_PC;
    endproperty
    a_overpop: assert property (p_overpop)
        else $error("overpop did not load 7fff");

    property p_ret_addr;
        @(posedge sysClk) disable iff (!resetn)
        s_trapLoad ##1 1'b1 |-> trapReturnAddr == $past(fetchAddr);
    endproperty
    a_ret_addr: assert property (p_ret_addr)
        else $error("trap return address wrong");

    property p_trap_vector;
        @(posedge sysClk) disable iff (!resetn)
        vectorSelectInstr && trapPending |=> vectorLow == VEC_TRAP;
    endproperty
    a_trap_vector: assert property (p_trap_vector)
        else $error("trap vector not selected");

    property p_port_vector;
        @(posedge sysClk) disable iff (!resetn)
        vectorSelectInstr && !trapPending && !trapEvent && periphReq == '0
            && portReq |=> vectorLow == VEC_PORT;
    endproperty
    a_port_vector: assert property (p_port_vector)
        else $error("port vector not e2");

    property p_no_irq_blocked;
        @(posedge sysClk) disable iff (!resetn)
        bootActive || trapPending || svc != SVC_NONE |-> !irqToCore;
    endproperty
    a_no_irq_blocked: assert property (p_no_irq_blocked)
        else $error("request raised while blocked");

    property p_port_req;
        @(posedge sysClk) disable iff (!resetn)
        portReq == (global_irq_enable && groupEn && (wakeEn & wakePend) != 8'h00);
    endproperty
    a_port_req: assert property (p_port_req)
        else $error("port request gating wrong");

    property p_edge_latch;
        @(posedge sysClk) disable iff (!resetn)
        pinSync2 != pinPrev |=> (wakePend & $past(edgeHit)) == $past(edgeHit);
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("edge not latched in pending");

    property p_wake_isr;
        @(posedge sysClk) disable iff (!resetn)
        wakeToIsr |-> wakeup && global_irq_enable && groupEn;
    endproperty
    a_wake_isr: assert property (p_wake_isr)
        else $error("wake to routine without enable");

endmodule : ptw_irq_ctrl

// ### ptw_core_model.sv
// Core-side model: fetch, stack pops, instruction events and sources
`timescale 1ns/10ps
module ptw_core_model
    import ptw_pkg::*;
(
    // Clock
    input wire logic sysClk,
    // Fetch and stack
    output logic fetchLoad,
    output logic [14:0] fetchAddr,
    output logic [7:0] flashData,
    output logic stackPop,
    output logic [7:0] stackPopAddr,
    // Accept, return, vector select, clear pending (bit 3 down to 0)
    output logic [3:0] ev,
    // Request sources and core state
    output logic [NUM_LINES-1:0] portPins,
    output logic [NUM_PERIPH-1:0] periphReq,
    output logic bootActive,
    output logic haltIdle
);
    initial begin
        fetchLoad = 1'b0;
        fetchAddr = 15'h0000;
        flashData = 8'hff;
        stackPop = 1'b0;
        stackPopAddr = 8'h00;
        ev = 4'h0;
        portPins = '0;
        periphReq = '0;
        bootActive = 1'b0;
        haltIdle = 1'b0;
    end

    ////////////////////////////////////////
    task automatic fetch(input logic [14:0] a, input logic [7:0] d);
        @(posedge sysClk);
        fetchLoad <= 1'b1;
        fetchAddr <= a;
        flashData <= d;
        @(posedge sysClk);
        fetchLoad <= 1'b0;
        // Released bus shows junk, so a stale byte cannot pass for data
        fetchAddr <= ~a;
        flashData <= ~d;
    endtask : fetch

    task automatic pop(input logic [7:0] a);
        @(posedge sysClk);
        stackPop <= 1'b1;
        stackPopAddr <= a;
        @(posedge sysClk);
        stackPop <= 1'b0;
        stackPopAddr <= ~a;
    endtask : pop

    task automatic pulse(input int i);
        @(posedge sysClk);
        ev <= 4'h1 << i;
        @(posedge sysClk);
        ev <= 4'h0;
    endtask : pulse

    // Handler restarts rather than resumes; two clears guard a nested trap
    task automatic recover();
        pulse(0);
        pulse(0);
    endtask : recover

    task automatic setPins(input logic [NUM_LINES-1:0] p);
        @(posedge sysClk);
        portPins <= p;
    endtask : setPins

    task automatic setCore(input logic [NUM_PERIPH-1:0] p, input logic b,
                           input logic h);
        @(posedge sysClk);
        periphReq <= p;
        bootActive <= b;
        haltIdle <= h;
    endtask : setCore
endmodule : ptw_core_model

// ### ptw_irq_ctrl_tb.sv
// Self-checking bench for the trap and edge-wake interrupt logic
`timescale 1ns/10ps
module ptw_irq_ctrl_tb
    import ptw_pkg::*;
;
    logic sysClk, resetn, isr;
    ptw_apb_req_t apbReq;
    ptw_apb_rsp_t apbRsp;
    logic fetchLoad, instrValid, stackPop, pcLoad, trapTaken, irqToCore;
    logic bootActive, haltIdle, wakeup, wakeToIsr;
    logic [14:0] fetchAddr, pcLoadValue, trapReturnAddr;
    logic [7:0] flashData, instrOut, stackPopAddr, vectorLow;
    logic [3:0] ev;
    logic [NUM_PERIPH-1:0] periphReq;
    logic [NUM_LINES-1:0] portPins;
    logic [31:0] rd;
    int errors, checksDone;
    logic [14:0] fAddr [5] = '{15'h0100, 15'h0101, 15'h1fff, 15'h2000,
                               15'h7fff};
    logic [7:0] fData [5] = '{8'h5a, 8'h00, 8'ha5, 8'h5a, 8'h5a};
    logic [7:0] fExp [5] = '{8'h5a, 8'h00, 8'ha5, 8'h00, 8'h00};
    logic [4:0] fTrap = 5'b11010;

    ptw_irq_ctrl i_dut (
        .sysClk, .resetn, .apbReq, .apbRsp, .fetchLoad, .fetchAddr,
        .flashData, .instrValid, .instrOut, .stackPop, .stackPopAddr,
        .pcLoad, .pcLoadValue, .trapTaken, .trapReturnAddr,
        .clearPendingInstr(ev[0]), .vectorSelectInstr(ev[1]),
        .returnFromIrqInstr(ev[2]), .irqAccepted(ev[3]),
        .vectorLow, .irqToCore, .periphReq, .bootActive, .haltIdle,
        .wakeup, .wakeToIsr, .portPins
    );
    ptw_core_model i_core (
        .sysClk, .fetchLoad, .fetchAddr, .flashData, .stackPop,
        .stackPopAddr, .ev, .portPins, .periphReq, .bootActive, .haltIdle
    );

    initial begin
        sysClk = 1'b0;
        forever #2 sysClk = ~sysClk;
    end

    initial begin
        repeat (20000) @(posedge sysClk);
        errors++;
        endSim();
    end

    ////////////////////////////////////////
    task automatic endSim();
        $display("errors %0d checks %0d", errors, checksDone);
        if (errors == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : endSim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read data is taken at the pready edge, before registers update
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic e);
        int n;
        @(posedge sysClk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge sysClk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sysClk);
            if (apbRsp.pready === 1'b1) break;
        end
        rd = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq <= '0;
        if (n == 16) begin
            errors++;
            endSim();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
        #1;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        logic e;
        apb(1'b0, a, 32'h0, e);
        chk(rd, x);
    endtask : rc

    task automatic vec(input logic [7:0] x);
        i_core.pulse(1);
        #1;
        chk(vectorLow, x);
    endtask : vec

    // Two sync flops plus the latch: four edges always suffice
    task automatic pins(input logic [NUM_LINES-1:0] p);
        i_core.setPins(p);
        repeat (4) @(posedge sysClk);
        #1;
    endtask : pins

    task automatic catchWake();
        int n;
        for (n = 0; n < 16; n++) begin
            @(posedge sysClk);
            #1;
            if (wakeup === 1'b1) break;
        end
        if (n == 16) begin
            errors++;
            endSim();
        end
        isr = wakeToIsr;
    endtask : catchWake

    task automatic rst();
        resetn <= 1'b0;
        repeat (2) @(posedge sysClk);
        resetn <= 1'b1;
    endtask : rst

    ////////////////////////////////////////
    initial begin
        errors = 0;
        checksDone = 0;
        apbReq = '0;
        resetn = 1'b0;
        rst();
        #1;
        chk({trapTaken, vectorLow}, 9'h0e0);
        rc(CTRL_OFS, 32'h0);
        rc(WAKE_EN_OFS, 32'h0);
        rc(WAKE_EDGE_OFS, 32'h0);
        rc(WAKE_PEND_OFS, 32'h0);
        apb(1'b1, 8'h18, 32'hffffffff, isr);
        chk(isr, 1);
        apb(1'b0, 8'h18, 32'h0, isr);
        chk(isr, 1);
        chk(rd, 0);
        for (int i = 0; i < 5; i++) begin
            i_core.fetch(fAddr[i], fData[i]);
            #1;
            chk({instrValid, instrOut}, {1'b1, fExp[i]});
            chk(trapTaken, fTrap[i]);
            if (fTrap[i]) chk(trapReturnAddr, fAddr[i]);
        end
        i_core.recover();
        i_core.pulse(2);
        i_core.pop(8'h6f);
        #1;
        chk(pcLoad, 0);
        i_core.pop(8'h70);
        #1;
        chk({pcLoad, pcLoadValue}, {1'b1, 15'h7fff});
        wr(CTRL_OFS, 32'h3);
        wr(WAKE_EN_OFS, 32'h3);
        wr(WAKE_EDGE_OFS, 32'h2);
        pins(8'h03);
        chk(irqToCore, 1);
        rc(WAKE_PEND_OFS, 32'h1);
        pins(8'h00);
        rc(WAKE_PEND_OFS, 32'h3);
        pins(8'h80);
        rc(WAKE_PEND_OFS, 32'h83);
        wr(WAKE_PEND_OFS, 32'h3);
        rc(WAKE_PEND_OFS, 32'h80);
        #1;
        chk(irqToCore, 0);
        wr(WAKE_EN_OFS, 32'h80);
        chk(irqToCore, 1);
        vec(8'he2);
        rc(VECTOR_OFS, 32'he2);
        rc(STATUS_OFS, 32'h9);
        wr(CTRL_OFS, 32'h1);
        chk(irqToCore, 0);
        wr(CTRL_OFS, 32'h2);
        chk(irqToCore, 0);
        wr(CTRL_OFS, 32'h3);
        for (int i = 0; i < NUM_PERIPH; i++) begin
            i_core.setCore({NUM_PERIPH{1'b1}} << i, 1'b0, 1'b0);
            vec(8'hfa - 8'(2 * i));
        end
        i_core.setCore('0, 1'b0, 1'b0);
        i_core.fetch(15'h0200, 8'h00);
        #1;
        chk({trapTaken, irqToCore}, 2'b10);
        rc(CTRL_OFS, 32'h3);
        rc(STATUS_OFS, 32'h1);
        vec(8'hfe);
        i_core.pulse(2);
        vec(8'hfe);
        i_core.fetch(15'h0210, 8'h00);
        #1;
        chk(trapTaken, 1);
        i_core.recover();
        #1;
        chk(irqToCore, 0);
        i_core.pulse(2);
        #1;
        chk(irqToCore, 1);
        i_core.pulse(3);
        #1;
        chk(irqToCore, 0);
        i_core.fetch(15'h0220, 8'h00);
        #1;
        chk(trapTaken, 1);
        i_core.recover();
        i_core.pulse(2);
        i_core.pulse(2);
        i_core.setCore('0, 1'b1, 1'b0);
        #1;
        chk(irqToCore, 0);
        rc(CTRL_OFS, 32'h3);
        pins(8'h00);
        pins(8'h80);
        apb(1'b0, STATUS_OFS, 32'h0, isr);
        chk(rd[2:1], 2'b11);
        i_core.setCore('0, 1'b0, 1'b0);
        #1;
        chk(irqToCore, 1);
        wr(STATUS_OFS, 32'h4);
        apb(1'b0, STATUS_OFS, 32'h0, isr);
        chk(rd[2], 0);
        wr(WAKE_PEND_OFS, 32'h80);
        wr(CTRL_OFS, 32'h0);
        i_core.setCore('0, 1'b0, 1'b1);
        pins(8'h00);
        i_core.setPins(8'h80);
        catchWake();
        chk(isr, 0);
        wr(WAKE_PEND_OFS, 32'h80);
        wr(CTRL_OFS, 32'h3);
        pins(8'h00);
        i_core.setPins(8'h80);
        catchWake();
        chk(isr, 1);
        i_core.setCore('0, 1'b0, 1'b0);
        i_core.setPins(8'h00);
        i_core.fetch(15'h0230, 8'h00);
        rst();
        rc(CTRL_OFS, 32'h0);
        vec(8'he0);
        endSim();
    end
endmodule : ptw_irq_ctrl_tb
